// ==== hdl/bprc_reset_ctrl.sv ====
// bprc_reset_ctrl.sv: brown-out and power-up reset sequencer with ahb-lite slave
// assumes: detector, power-on and source inputs are asynchronous pins; the
// configuration word is static after power-on; one 250 MHz clock
`include "bprc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bprc_reset_ctrl #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES   = (`BPRC_POWERUP_DELAY_TIMER_MS * 1000 * `BPRC_CLK_MHZ),
  parameter int unsigned FILTER_CYCLES = (`BPRC_FILTER_NS * `BPRC_CLK_MHZ) / 1000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  brownout_mode_sel,
  input  wire logic        brownout_level_sel,
  input  wire logic        powerup_delay_enable_n,
  input  wire logic        power_ok,
  input  wire logic        brownout_trip,
  input  wire logic        brownout_ready,
  input  wire logic        low_power_brownout,
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_reset,
  input  wire logic        reset_instr,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  input  wire logic        prog_mode_exit,
  input  wire logic        sleep_req,
  output logic             brownout_enable,
  output logic             brownout_threshold,
  output logic             band_gap_force,
  output logic             core_reset_n,
  output logic             wake_ok
);

  // --------------------------------------------------------------------------
  // synchronisers: first stage read only by the second
  // --------------------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  assign async_in = {prog_mode_exit, stack_underflow, stack_overflow, reset_instr,
                     watchdog_reset, ~external_reset_pin_n, low_power_brownout,
                     brownout_ready, brownout_trip, power_ok, sleep_req};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  wire s_sleep      = sync2_r[0];
  wire s_power_ok   = sync2_r[1];
  wire s_trip       = sync2_r[2];
  wire s_ready      = sync2_r[3];
  wire s_other_rst  = |sync2_r[10:4];
  wire s_prog_exit  = sync2_r[10];

  // --------------------------------------------------------------------------
  // control register and mode decode
  // --------------------------------------------------------------------------
  logic sw_en_r;
  logic fast_start_r;
  bprc_pkg::bprc_mode_e mode;
  assign mode = bprc_pkg::bprc_mode_e'(brownout_mode_sel);

  wire mode_on  = (mode == bprc_pkg::BPRC_MODE_ON);
  wire mode_nsl = (mode == bprc_pkg::BPRC_MODE_NSL);
  wire mode_sw  = (mode == bprc_pkg::BPRC_MODE_SW);

  // detector power: mode 10 drops it in sleep, mode 01 follows software
  assign brownout_enable = mode_on
                         | (mode_nsl & ~s_sleep)
                         | (mode_sw & sw_en_r);
  assign brownout_threshold = brownout_level_sel;
  assign band_gap_force = (mode_nsl | mode_sw) & fast_start_r;

  // protection armed only once the detector says ready
  wire bor_armed = brownout_enable & s_ready;

  // --------------------------------------------------------------------------
  // brown-out filter: short dips are ignored
  // --------------------------------------------------------------------------
  logic [15:0] filt_r;
  logic        bor_hold_r;
  wire         filt_done = (filt_r >= FILTER_CYCLES[15:0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_r     <= 16'h0000;
      bor_hold_r <= 1'b0;
    end else begin
      if (bor_armed && s_trip && !filt_done) begin
        filt_r <= filt_r + 16'h0001;
      end else if (!(bor_armed && s_trip)) begin
        filt_r <= 16'h0000;
      end
      bor_hold_r <= bor_armed & s_trip & filt_done;
    end
  end

  // --------------------------------------------------------------------------
  // reset sequencer
  // --------------------------------------------------------------------------
  bprc_pkg::bprc_state_e state_r;
  bprc_pkg::bprc_state_e state_nxt;
  logic [24:0] powerup_delay_timer_r;
  logic        powerup_delay_timer_busy;
  logic        core_rst_n_r;

  wire por_hold   = ~s_power_ok | s_prog_exit;
  wire bor_start  = (mode_on | mode_nsl) & ~bor_armed;
  wire powerup_delay_timer_on    = ~powerup_delay_enable_n;
  wire powerup_delay_timer_last  = (powerup_delay_timer_r == POWERUP_DELAY_TIMER_CYCLES[24:0] - 25'h0000001);
  assign powerup_delay_timer_busy = (state_r == bprc_pkg::BPRC_ST_TIMER);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bprc_pkg::BPRC_ST_HOLD:
        if (!por_hold && !bor_hold_r) begin
          state_nxt = bprc_pkg::BPRC_ST_WAIT_BOR;
        end
      bprc_pkg::BPRC_ST_WAIT_BOR:
        if (!bor_start) begin
          state_nxt = powerup_delay_timer_on ? bprc_pkg::BPRC_ST_TIMER
                              : bprc_pkg::BPRC_ST_RUN;
        end
      bprc_pkg::BPRC_ST_TIMER:
        if (powerup_delay_timer_last) begin
          state_nxt = bprc_pkg::BPRC_ST_RUN;
        end
      bprc_pkg::BPRC_ST_RUN:
        if (s_sleep && mode_nsl) begin
          state_nxt = bprc_pkg::BPRC_ST_WAKE;
        end
      bprc_pkg::BPRC_ST_WAKE:
        if (!s_sleep && bor_armed) begin
          state_nxt = bprc_pkg::BPRC_ST_RUN;
        end
    endcase
    if (por_hold || bor_hold_r) begin
      state_nxt = bprc_pkg::BPRC_ST_HOLD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= bprc_pkg::BPRC_ST_HOLD;
      powerup_delay_timer_r  <= 25'h0000000;
    end else begin
      state_r <= state_nxt;
      powerup_delay_timer_r  <= powerup_delay_timer_busy ? powerup_delay_timer_r + 25'h0000001 : 25'h0000000;
    end
  end

  // release only from a flop, after every hold is gone
  wire run_state = (state_r == bprc_pkg::BPRC_ST_RUN) | (state_r == bprc_pkg::BPRC_ST_WAKE);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_rst_n_r <= 1'b0;
    end else begin
      core_rst_n_r <= run_state & ~s_other_rst;
    end
  end
  assign core_reset_n = core_rst_n_r;
  // wake blocked in mode 10 until ready; modes 11 and 01 never delay it
  assign wake_ok = (state_r == bprc_pkg::BPRC_ST_RUN) & core_rst_n_r;

  // --------------------------------------------------------------------------
  // ahb-lite slave, zero wait states, always okay
  // --------------------------------------------------------------------------
  logic        wr_pend_r;
  logic [11:0] addr_r;
  wire         take = hsel & hready & htrans[1];
  wire         hit_ctrl = (addr_r == `BPRC_OFS_CONTROL);
  wire         hit_stat = (haddr[11:0] == `BPRC_OFS_STATUS);
  wire         rd_ctrl  = (haddr[11:0] == `BPRC_OFS_CONTROL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end else begin
      wr_pend_r <= take & hwrite;
      addr_r    <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_en_r      <= `BPRC_RST_SW_EN;
      fast_start_r <= `BPRC_RST_FAST_START;
    end else if (wr_pend_r && hit_ctrl) begin
      sw_en_r      <= hwdata[`BPRC_BIT_SW_EN];
      fast_start_r <= hwdata[`BPRC_BIT_FAST_START];
    end
  end

  // read data registered at the address phase so it stands in the data phase
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[`BPRC_BIT_SW_EN]      = sw_en_r;
    ctrl_word[`BPRC_BIT_FAST_START] = fast_start_r;
    ctrl_word[`BPRC_BIT_READY]      = bor_armed;
    stat_word = 32'h00000000;
    stat_word[`BPRC_BIT_ST_POR]      = por_hold;
    stat_word[`BPRC_BIT_ST_BOR]      = bor_hold_r;
    stat_word[`BPRC_BIT_ST_TIMER]    = powerup_delay_timer_busy;
    stat_word[`BPRC_BIT_ST_RESET]    = ~core_rst_n_r;
    stat_word[`BPRC_BIT_ST_ACTIVE]   = brownout_enable;
    stat_word[`BPRC_BIT_ST_BAND_GAP] = band_gap_force;
    stat_word[`BPRC_BIT_ST_SLEEP]    = s_sleep;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= rd_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h00000000);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  a_por_holds_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    por_hold |=> ##1 !core_reset_n) else $error("reset released while power not ok");
  a_timer_blocks_run: assert property (@(posedge hclk) disable iff (!hresetn)
    powerup_delay_timer_busy |=> !core_reset_n) else $error("reset released during timer");
  a_timer_starts: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(powerup_delay_timer_busy) |-> $past(!por_hold && !bor_start)) else $error("timer early start");
  a_timer_length: assert property (@(posedge hclk) disable iff (!hresetn)
    (powerup_delay_timer_busy && powerup_delay_timer_last && !por_hold && !bor_hold_r) |=> !powerup_delay_timer_busy)
    else $error("timer ran past its count");
  a_timer_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    powerup_delay_enable_n |=> !$rose(powerup_delay_timer_busy)) else $error("timer ran while disabled");
  a_filter_short: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(bor_hold_r) |-> $past(filt_done)) else $error("brown-out trip not filtered");
  a_sw_enable_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_on || (mode == bprc_pkg::BPRC_MODE_OFF)) |-> brownout_enable == mode_on)
    else $error("software enable acted outside mode 01");
  a_band_gap_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    band_gap_force |-> (fast_start_r && (mode_nsl || mode_sw))) else $error("band gap mode");
  a_ready_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && rd_ctrl) |=> (hrdata[5:1] == 5'h00 && hrdata[0] == $past(bor_armed)))
    else $error("ready bit readback wrong");
  a_release_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(core_reset_n) |-> $past(run_state && !s_other_rst)) else $error("bad release");

  c_timer_done: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(powerup_delay_timer_busy) ##1 core_reset_n);
  c_brownout: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bor_hold_r));
  c_wake_wait: cover property (@(posedge hclk) disable iff (!hresetn)
    state_r == bprc_pkg::BPRC_ST_WAKE);

endmodule : bprc_reset_ctrl

`default_nettype wire

// ==== hdl/bprc_cfg.svh ====
// bprc_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the reset sequencer sources
`ifndef BPRC_CFG_SVH
`define BPRC_CFG_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define BPRC_OFS_CONTROL     12'h000
`define BPRC_OFS_STATUS      12'h004

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define BPRC_BIT_SW_EN       7
`define BPRC_BIT_FAST_START  6
`define BPRC_BIT_READY       0
`define BPRC_RST_SW_EN       1'b1
`define BPRC_RST_FAST_START  1'b0

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define BPRC_BIT_ST_POR      0
`define BPRC_BIT_ST_BOR      1
`define BPRC_BIT_ST_TIMER    2
`define BPRC_BIT_ST_RESET    3
`define BPRC_BIT_ST_ACTIVE   4
`define BPRC_BIT_ST_BAND_GAP 5
`define BPRC_BIT_ST_SLEEP    6

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define BPRC_CLK_MHZ         250
`define BPRC_POWERUP_DELAY_TIMER_MS         64
`define BPRC_FILTER_NS       1000
`define BPRC_SYNC_CYCLES     2

`endif

// ==== hdl/bprc_pkg.sv ====
// bprc_pkg.sv: types of the brown-out and power-up reset sequencer
// assumes: nothing beyond the tool's SystemVerilog support
package bprc_pkg;

  // brown-out mode field from the configuration word
  typedef enum logic [1:0] {
    BPRC_MODE_OFF = 2'h0,
    BPRC_MODE_SW  = 2'h1,
    BPRC_MODE_NSL = 2'h2,
    BPRC_MODE_ON  = 2'h3
  } bprc_mode_e;

  // reset sequencing states
  typedef enum logic [2:0] {
    BPRC_ST_HOLD,
    BPRC_ST_WAIT_BOR,
    BPRC_ST_TIMER,
    BPRC_ST_RUN,
    BPRC_ST_WAKE
  } bprc_state_e;

endpackage : bprc_pkg

// ==== dv/tb_bprc_reset_ctrl.sv ====
// tb_bprc_reset_ctrl.sv: self-checking bench for the reset sequencer
// assumes: design sources under hdl/ compiled first; short timer and filter counts
`timescale 1ns/1ps
`default_nettype none

module tb_bprc_reset_ctrl;
  // ---------------------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------------------
  localparam int unsigned POWERUP_DELAY_TIMER = 50;
  localparam int unsigned FILT = 4;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0, mode = 2'h3;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, bo_en, bo_thr, bg_force, core_reset_n, wake_ok;
  logic        level_sel = 1'b0, powerup_delay_timer_en_n = 1'b0, power_ok = 1'b1, trip = 1'b0;
  logic        ready = 1'b1, lp_bo = 1'b0, ext_n = 1'b1, wdog = 1'b0, sleep = 1'b0;
  int          miscompares = 0, checks = 0;
  logic [31:0] rd;

  always #2 hclk = ~hclk;

  bprc_reset_ctrl #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER), .FILTER_CYCLES(FILT)) bprc_reset_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .brownout_mode_sel(mode), .brownout_level_sel(level_sel),
    .powerup_delay_enable_n(powerup_delay_timer_en_n), .power_ok(power_ok), .brownout_trip(trip),
    .brownout_ready(ready), .low_power_brownout(lp_bo), .external_reset_pin_n(ext_n),
    .watchdog_reset(wdog), .reset_instr(1'b0), .stack_overflow(1'b0),
    .stack_underflow(1'b0), .prog_mode_exit(1'b0), .sleep_req(sleep),
    .brownout_enable(bo_en), .brownout_threshold(bo_thr), .band_gap_force(bg_force),
    .core_reset_n(core_reset_n), .wake_ok(wake_ok));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // both bus phases wait on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    // start the address phase just after a rising edge
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    rd = hrdata;
  endtask : bus

  task automatic wait_core(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && core_reset_n !== v; i++) @(posedge hclk);
    #1 check({31'h0, core_reset_n}, {31'h0, v});
  endtask : wait_core

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    wait_core(1'b1, POWERUP_DELAY_TIMER + 40);
    bus(1'b0, 32'h0, 32'h0); check(rd, 32'h81);
    bus(1'b0, 32'h8, 32'h0); check(rd, 32'h0);
    bus(1'b0, 32'h4, 32'h0); check(rd, 32'h10);
    check({31'h0, hresp}, 32'h0);
    bus(1'b1, 32'h0, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0, 32'h0); check(rd, 32'hC1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_powerup;
    @(posedge hclk) power_ok <= 1'b0;
    repeat (6) @(posedge hclk);
    #1 check({31'h0, core_reset_n}, 32'h0);
    @(posedge hclk) power_ok <= 1'b1;
    repeat (POWERUP_DELAY_TIMER - 5) @(posedge hclk);
    #1 check({31'h0, core_reset_n}, 32'h0);
    wait_core(1'b1, 40);
    // hold power low long enough that the release must start from hold
    @(posedge hclk) begin
      powerup_delay_timer_en_n <= 1'b1;
      power_ok  <= 1'b0;
    end
    repeat (6) @(posedge hclk);
    #1 check({31'h0, core_reset_n}, 32'h0);
    @(posedge hclk) power_ok <= 1'b1;
    wait_core(1'b1, 15);
    powerup_delay_timer_en_n <= 1'b0;
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_filter;
    @(posedge hclk) trip <= 1'b1;
    repeat (FILT - 2) @(posedge hclk);
    trip <= 1'b0;
    repeat (10) @(posedge hclk);
    #1 check({31'h0, core_reset_n}, 32'h1);
    @(posedge hclk) trip <= 1'b1;
    wait_core(1'b0, FILT + 10);
    @(posedge hclk) trip <= 1'b0;
    repeat (POWERUP_DELAY_TIMER - 5) @(posedge hclk);
    #1 check({31'h0, core_reset_n}, 32'h0);
    wait_core(1'b1, 40);
    @(posedge hclk) wdog <= 1'b1;
    wait_core(1'b0, 10);
    @(posedge hclk) wdog <= 1'b0;
    wait_core(1'b1, 20);
    $display("test filter done");
  endtask : t_filter

  // mode 01 obeys the enable bit, other modes ignore it
  task automatic t_modes;
    bus(1'b1, 32'h0, 32'h0);
    #1 check({31'h0, bo_en}, 32'h1);
    @(posedge hclk) mode <= 2'h1;
    #1 check({31'h0, bo_en}, 32'h0);
    bus(1'b0, 32'h0, 32'h0); check(rd, 32'h0);
    bus(1'b1, 32'h0, 32'hC0);
    #1 check({30'h0, bo_en, bg_force}, 32'h3);
    @(posedge hclk) mode <= 2'h0;
    #1 check({30'h0, bo_en, bg_force}, 32'h0);
    @(posedge hclk) begin
      mode <= 2'h1; sleep <= 1'b1; level_sel <= 1'b1;
    end
    // let sleep pass the synchroniser before judging it
    repeat (3) @(posedge hclk);
    #1 check({30'h0, bo_en, bo_thr}, 32'h3);
    $display("test modes done");
  endtask : t_modes

  task automatic t_sleep;
    int i;
    @(posedge hclk) mode <= 2'h2;
    #1 check({31'h0, bo_en}, 32'h0);
    @(posedge hclk) ready <= 1'b0;
    repeat (4) @(posedge hclk) sleep <= 1'b0;
    repeat (4) @(posedge hclk);
    #1 check({30'h0, wake_ok, core_reset_n}, 32'h1);
    @(posedge hclk) ready <= 1'b1;
    for (i = 0; i < 20 && wake_ok !== 1'b1; i++) @(posedge hclk);
    #1 check({31'h0, wake_ok}, 32'h1);
    @(posedge hclk) mode <= 2'h3;
    repeat (3) @(posedge hclk) sleep <= 1'b1;
    #1 check({30'h0, bo_en, wake_ok}, 32'h3);
    $display("test sleep done");
  endtask : t_sleep

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_powerup();
    t_filter();
    t_modes();
    t_sleep();
    complete_run();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule : tb_bprc_reset_ctrl
`default_nettype wire
